/* inc/tsic_pkg.sv */
// How it works
// - Every trigger source owns its own enable bit, settable alone or in groups.
// - One enable write changes all addressed bits in the same clock cycle.
// - Sources: four inputs, four references, gated reference, interval, pulse, timer; plus all-selector.
// - The pulse counter waits idle until its selected start pulse arms it.
// - Armed, each selected trigger pulse decrements the count and passes on as event.
// - At count zero every further trigger pulse is blocked.
// - Reconfiguring while the count is above zero reloads the initial value.
// - The pulse count start value is 20 bits, zero to all ones.
// - Start choices: inputs, references, software channels, gated reference, interval counter.
// - Trigger choices: inputs, references, gated reference, interval counter, timer; no software.
// - Interpolation factor is 1, 2, 4, 5, 10, 20, 25, 50 or 100.
// - Counting steps per period equal interpolation times edge evaluation of 1, 2, 4.
// - The step setting drives both the interval counter and the auxiliary axis count.
// - Interval counter modes are off, one shot at a position, and repeat.
// - One shot mode pulses once when the position equals the programmed position.
// - Repeat mode pulses at the start position, then every programmed interval of steps.
// - Start is either the programmed position or the position captured at configuration.
// - The enabled timer source pulses at the end of each period of timer ticks.
package tsic_pkg;
   localparam int NUM_CH = 4;
   localparam int NUM_SRC = 12;
   localparam int SRC_TRIG_IN0 = 0;
   localparam int SRC_REF0 = 4;
   localparam int SRC_GATED = 8;
   localparam int SRC_IC = 9;
   localparam int SRC_PC = 10;
   localparam int SRC_TIMER = 11;
   localparam logic [NUM_SRC-1:0] ENABLE_RST = 12'h000;
   localparam int PS_TRIG_IN0 = 0;
   localparam int PS_REF0 = 4;
   localparam int PS_SW0 = 8;
   localparam int PS_GATED = 12;
   localparam int PS_IC = 13;
   localparam int PS_NUM = 14;
   localparam int PT_TRIG_IN0 = 0;
   localparam int PT_REF0 = 4;
   localparam int PT_GATED = 8;
   localparam int PT_IC = 9;
   localparam int PT_TIMER = 10;
   localparam int PT_NUM = 11;
   localparam int PC_COUNT_W = 20;
   localparam logic [PC_COUNT_W-1:0] PC_COUNT_RST = 20'h00000;
   localparam int POS_W = 32;
   localparam int FINE_W = 9;
   localparam logic [FINE_W-1:0] FINE_PER_PERIOD = 9'h190;
   localparam int TMR_W = 32;
   typedef enum logic [1:0] {interval_mode_off, interval_mode_one_shot, interval_mode_repeat} tsic_ic_mode_t;
   typedef enum logic {start_at_programmed_position, start_at_present_position} tsic_ic_start_t;
   typedef enum logic [3:0] {interp_1x, interp_2x, interp_4x, interp_5x, interp_10x, interp_20x, interp_25x,
                             interp_50x, interp_100x} tsic_interp_t;
   typedef enum logic [1:0] {single_edge_evaluation, double_edge_evaluation,
                             quadruple_edge_evaluation} tsic_edge_t;
   typedef struct packed {
      logic enable;
      logic all_sources_selector;
      logic [NUM_SRC-1:0] mask;
   } tsic_src_wr_t;
   typedef struct packed {
      logic [3:0] start_sel;
      logic [3:0] trig_sel;
      logic [PC_COUNT_W-1:0] count;
   } tsic_pc_cfg_t;
   typedef struct packed {
      tsic_ic_mode_t mode;
      tsic_ic_start_t start_sel;
      logic [POS_W-1:0] start_pos;
      logic [POS_W-1:0] interval;
   } tsic_ic_cfg_t;
endpackage

/* hdl/tsic_trigger_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module tsic_trigger_unit
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [tsic_pkg::NUM_CH-1:0] i_trig_in,
   input wire logic [tsic_pkg::NUM_CH-1:0] i_ref_pulse,
   input wire logic i_track_a,
   input wire logic i_track_b,
   input wire logic [tsic_pkg::NUM_CH-1:0] i_sw_trigger,
   input wire logic i_timer_tick,
   input wire logic [tsic_pkg::TMR_W-1:0] i_timer_period,
   input wire logic i_fine_step,
   input wire logic i_fine_dir_down,
   input wire logic i_src_write,
   input wire tsic_pkg::tsic_src_wr_t i_src_cfg,
   input wire logic i_pc_write,
   input wire tsic_pkg::tsic_pc_cfg_t i_pc_cfg,
   input wire logic i_step_write,
   input wire tsic_pkg::tsic_interp_t i_interp,
   input wire tsic_pkg::tsic_edge_t i_edge,
   input wire logic i_ic_write,
   input wire tsic_pkg::tsic_ic_cfg_t i_ic_cfg,
   output logic [tsic_pkg::NUM_SRC-1:0] o_trig_events,
   output logic o_trig_any,
   output logic [tsic_pkg::NUM_SRC-1:0] o_src_enable,
   output logic [tsic_pkg::PC_COUNT_W-1:0] o_pc_value,
   output logic o_pc_armed,
   output logic o_pc_done,
   output logic [tsic_pkg::POS_W-1:0] o_aux_position,
   output tsic_pkg::tsic_ic_mode_t o_ic_mode
);
   typedef enum logic [1:0] {PC_IDLE, PC_ARMED, PC_DONE} tsic_pc_state_t;

   logic [9:0] sync1_r;
   logic [9:0] sync2_r;
   logic [9:0] last_r;
   logic [tsic_pkg::NUM_CH-1:0] trig_edge;
   logic [tsic_pkg::NUM_CH-1:0] ref_edge;
   logic gated_edge;
   logic [tsic_pkg::NUM_SRC-1:0] enable_r;
   logic [tsic_pkg::NUM_SRC-1:0] enable_nxt;
   logic [tsic_pkg::NUM_SRC-1:0] raw_events;
   logic [tsic_pkg::NUM_SRC-1:0] events_r;
   logic timer_fire_r;
   logic [tsic_pkg::TMR_W-1:0] timer_cnt_r;
   tsic_pkg::tsic_interp_t interp_r;
   tsic_pkg::tsic_edge_t edge_r;
   logic [tsic_pkg::FINE_W-1:0] divisor;
   logic [tsic_pkg::FINE_W-1:0] fine_cnt_r;
   logic step_up;
   logic step_down;
   logic [tsic_pkg::POS_W-1:0] aux_pos_r;
   tsic_pkg::tsic_ic_mode_t ic_mode_r;
   logic [tsic_pkg::POS_W-1:0] ic_target_r;
   logic [tsic_pkg::POS_W-1:0] ic_interval_r;
   logic ic_armed_r;
   logic ic_hit;
   logic ic_fire_r;
   tsic_pc_state_t pc_state_r;
   logic [tsic_pkg::PC_COUNT_W-1:0] pc_count_r;
   logic [tsic_pkg::PC_COUNT_W-1:0] pc_init_r;
   logic [3:0] pc_start_sel_r;
   logic [3:0] pc_trig_sel_r;
   logic [tsic_pkg::PS_NUM-1:0] pc_start_vec;
   logic [tsic_pkg::PT_NUM-1:0] pc_trig_vec;
   logic pc_start_hit;
   logic pc_trig_hit;
   logic pc_fire_r;

   // Counting step width in fine units: full resolution divided by interpolation times edge evaluation.
   function automatic logic [tsic_pkg::FINE_W-1:0] step_divisor(input tsic_pkg::tsic_interp_t f,
                                                                input tsic_pkg::tsic_edge_t e);
      logic [tsic_pkg::FINE_W-1:0] base;
      base = tsic_pkg::FINE_PER_PERIOD;
      case (f)
         tsic_pkg::interp_1x: base = tsic_pkg::FINE_PER_PERIOD;
         tsic_pkg::interp_2x: base = 9'h0c8;
         tsic_pkg::interp_4x: base = 9'h064;
         tsic_pkg::interp_5x: base = 9'h050;
         tsic_pkg::interp_10x: base = 9'h028;
         tsic_pkg::interp_20x: base = 9'h014;
         tsic_pkg::interp_25x: base = 9'h010;
         tsic_pkg::interp_50x: base = 9'h008;
         tsic_pkg::interp_100x: base = 9'h004;
         default: base = tsic_pkg::FINE_PER_PERIOD;
      endcase
      case (e)
         tsic_pkg::double_edge_evaluation: step_divisor = base >> 1;
         tsic_pkg::quadruple_edge_evaluation: step_divisor = base >> 2;
         default: step_divisor = base;
      endcase
   endfunction

   // Pins cross into the clock domain through two flops; edges are taken only from the second stage.
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sync1_r <= 10'h000;
         sync2_r <= 10'h000;
         last_r <= 10'h000;
      end
      else
      begin
         sync1_r <= {i_track_b, i_track_a, i_ref_pulse, i_trig_in};
         sync2_r <= sync1_r;
         last_r <= sync2_r;
      end
   end

   assign trig_edge = sync2_r[3:0] & ~last_r[3:0];
   assign ref_edge = sync2_r[7:4] & ~last_r[7:4];
   // A reference mark only counts on axis 0 while both incremental tracks are high.
   assign gated_edge = ref_edge[0] & sync2_r[8] & sync2_r[9];

   always_comb
   begin
      enable_nxt = enable_r;
      if (i_src_write)
      begin
         if (i_src_cfg.all_sources_selector)
         begin
            enable_nxt = i_src_cfg.enable ? {tsic_pkg::NUM_SRC{1'b1}} : tsic_pkg::ENABLE_RST;
         end
         else if (i_src_cfg.enable)
         begin
            enable_nxt = enable_r | i_src_cfg.mask;
         end
         else
         begin
            enable_nxt = enable_r & ~i_src_cfg.mask;
         end
      end
   end

   // The whole mask lands in one register update, so grouped sources start together.
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         enable_r <= tsic_pkg::ENABLE_RST;
      end
      else
      begin
         enable_r <= enable_nxt;
      end
   end

   // The period input is expected stable before the timer source is enabled; zero acts as one.
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         timer_cnt_r <= '0;
         timer_fire_r <= 1'b0;
      end
      else
      begin
         timer_fire_r <= 1'b0;
         if (!enable_r[tsic_pkg::SRC_TIMER])
         begin
            timer_cnt_r <= '0;
         end
         else if (i_timer_tick)
         begin
            if (timer_cnt_r + 32'h0000_0001 >= i_timer_period)
            begin
               timer_cnt_r <= '0;
               timer_fire_r <= 1'b1;
            end
            else
            begin
               timer_cnt_r <= timer_cnt_r + 32'h0000_0001;
            end
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         interp_r <= tsic_pkg::interp_1x;
         edge_r <= tsic_pkg::quadruple_edge_evaluation;
      end
      else if (i_step_write)
      begin
         interp_r <= i_interp;
         edge_r <= i_edge;
      end
   end

   assign divisor = step_divisor(interp_r, edge_r);
   // A stale prescaler above the new divisor wraps on the next upward fine step instead of running away.
   assign step_up = i_fine_step && !i_fine_dir_down && (fine_cnt_r + 9'h001 >= divisor);
   assign step_down = i_fine_step && i_fine_dir_down && (fine_cnt_r == 9'h000);

   // One counted position feeds both the auxiliary axis and the interval counter.
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         fine_cnt_r <= '0;
         aux_pos_r <= '0;
      end
      else if (i_fine_step)
      begin
         if (step_up)
         begin
            fine_cnt_r <= '0;
            aux_pos_r <= aux_pos_r + 32'h0000_0001;
         end
         else if (step_down)
         begin
            fine_cnt_r <= divisor - 9'h001;
            aux_pos_r <= aux_pos_r - 32'h0000_0001;
         end
         else if (i_fine_dir_down)
         begin
            fine_cnt_r <= fine_cnt_r - 9'h001;
         end
         else
         begin
            fine_cnt_r <= fine_cnt_r + 9'h001;
         end
      end
   end

   assign ic_hit = ic_armed_r && (aux_pos_r == ic_target_r) && (ic_mode_r != tsic_pkg::interval_mode_off);

   // A write is assumed to follow a switch to off, so no pending target survives a reconfiguration.
   // Repeat targets only advance forward; travel in the negative direction gives no further pulses.
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ic_mode_r <= tsic_pkg::interval_mode_off;
         ic_target_r <= '0;
         ic_interval_r <= '0;
         ic_armed_r <= 1'b0;
         ic_fire_r <= 1'b0;
      end
      else if (i_ic_write)
      begin
         ic_mode_r <= i_ic_cfg.mode;
         ic_interval_r <= i_ic_cfg.interval;
         ic_armed_r <= (i_ic_cfg.mode != tsic_pkg::interval_mode_off);
         ic_fire_r <= 1'b0;
         if (i_ic_cfg.start_sel == tsic_pkg::start_at_present_position)
         begin
            ic_target_r <= aux_pos_r;
         end
         else
         begin
            ic_target_r <= i_ic_cfg.start_pos;
         end
      end
      else
      begin
         ic_fire_r <= ic_hit;
         if (ic_hit)
         begin
            if (ic_mode_r == tsic_pkg::interval_mode_repeat && ic_interval_r != '0)
            begin
               ic_target_r <= ic_target_r + ic_interval_r;
            end
            else
            begin
               ic_armed_r <= 1'b0;
            end
         end
      end
   end

   // Software channels may start the pulse counter but never feed it counted pulses.
   assign pc_start_vec = {ic_fire_r, gated_edge, i_sw_trigger, ref_edge, trig_edge};
   assign pc_trig_vec = {timer_fire_r, ic_fire_r, gated_edge, ref_edge, trig_edge};
   assign pc_start_hit = (pc_start_sel_r < 4'(tsic_pkg::PS_NUM)) && pc_start_vec[pc_start_sel_r];
   assign pc_trig_hit = (pc_trig_sel_r < 4'(tsic_pkg::PT_NUM)) && pc_trig_vec[pc_trig_sel_r];

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pc_state_r <= PC_IDLE;
         pc_count_r <= tsic_pkg::PC_COUNT_RST;
         pc_init_r <= tsic_pkg::PC_COUNT_RST;
         pc_start_sel_r <= 4'h0;
         pc_trig_sel_r <= 4'h0;
         pc_fire_r <= 1'b0;
      end
      else if (i_pc_write)
      begin
         pc_init_r <= i_pc_cfg.count;
         pc_count_r <= i_pc_cfg.count;
         pc_start_sel_r <= i_pc_cfg.start_sel;
         pc_trig_sel_r <= i_pc_cfg.trig_sel;
         pc_fire_r <= 1'b0;
         if (pc_state_r == PC_ARMED && pc_count_r != '0)
         begin
            pc_state_r <= PC_ARMED;
         end
         else
         begin
            pc_state_r <= PC_IDLE;
         end
      end
      else
      begin
         pc_fire_r <= 1'b0;
         case (pc_state_r)
            PC_IDLE:
            begin
               if (pc_start_hit)
               begin
                  pc_state_r <= PC_ARMED;
                  pc_count_r <= pc_init_r;
               end
            end
            PC_ARMED:
            begin
               if (pc_count_r == '0)
               begin
                  pc_state_r <= PC_DONE;
               end
               else if (pc_trig_hit)
               begin
                  pc_count_r <= pc_count_r - 20'h00001;
                  pc_fire_r <= 1'b1;
               end
            end
            PC_DONE:
            begin
               pc_state_r <= PC_DONE;
            end
            default:
            begin
               pc_state_r <= PC_IDLE;
            end
         endcase
      end
   end

   always_comb
   begin
      raw_events = '0;
      raw_events[tsic_pkg::SRC_TRIG_IN0 +: tsic_pkg::NUM_CH] = trig_edge;
      raw_events[tsic_pkg::SRC_REF0 +: tsic_pkg::NUM_CH] = ref_edge;
      raw_events[tsic_pkg::SRC_GATED] = gated_edge;
      raw_events[tsic_pkg::SRC_IC] = ic_fire_r;
      raw_events[tsic_pkg::SRC_PC] = pc_fire_r;
      raw_events[tsic_pkg::SRC_TIMER] = timer_fire_r;
   end

   // Every pin-derived source is a one-cycle pulse, so its gated copy is one cycle wide too.
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         events_r <= '0;
      end
      else
      begin
         events_r <= raw_events & enable_r;
      end
   end

   assign o_trig_events = events_r;
   assign o_trig_any = |events_r;
   assign o_src_enable = enable_r;
   assign o_pc_value = pc_count_r;
   assign o_pc_armed = (pc_state_r == PC_ARMED);
   assign o_pc_done = (pc_state_r == PC_DONE);
   assign o_aux_position = aux_pos_r;
   assign o_ic_mode = ic_mode_r;
endmodule
`default_nettype wire

/* dv/tsic_trigger_unit_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module tsic_trigger_unit_checker
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [tsic_pkg::NUM_CH-1:0] i_trig_in,
   input wire logic i_src_write,
   input wire tsic_pkg::tsic_src_wr_t i_src_cfg,
   input wire logic i_pc_write,
   input wire tsic_pkg::tsic_pc_cfg_t i_pc_cfg,
   input wire logic i_ic_write,
   input wire tsic_pkg::tsic_ic_cfg_t i_ic_cfg,
   input wire logic [tsic_pkg::NUM_SRC-1:0] o_trig_events,
   input wire logic o_trig_any,
   input wire logic [tsic_pkg::NUM_SRC-1:0] o_src_enable,
   input wire logic [tsic_pkg::PC_COUNT_W-1:0] o_pc_value,
   input wire logic o_pc_armed,
   input wire logic o_pc_done,
   input wire tsic_pkg::tsic_ic_mode_t o_ic_mode
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   sequence s_pin_rise;
      !i_trig_in[0] ##1 i_trig_in[0];
   endsequence
   chk_pin_walk: assert property (s_pin_rise ##0 o_src_enable[0] |-> ##3 o_trig_events[0])
      else $error("pin event missing");
   chk_any_or: assert property (o_trig_any == (|o_trig_events))
      else $error("any flag wrong");
   chk_evt_masked: assert property ((o_trig_events & ~$past(o_src_enable)) == 12'h000)
      else $error("event from disabled source");
   chk_pin_single: assert property ((o_trig_events[8:0] & $past(o_trig_events[8:0])) == 9'h000)
      else $error("pin event wider than a cycle");
   chk_src_all: assert property (i_src_write && i_src_cfg.all_sources_selector && i_src_cfg.enable
      |=> o_src_enable == 12'hfff)
      else $error("all selector failed");
   chk_src_group: assert property (i_src_write && !i_src_cfg.all_sources_selector && i_src_cfg.enable
      |=> o_src_enable == ($past(o_src_enable) | $past(i_src_cfg.mask)))
      else $error("group enable failed");
   chk_reset_clear: assert property ($rose(i_rst_n) |-> o_src_enable == 12'h000 && !o_pc_armed
      && o_ic_mode == tsic_pkg::interval_mode_off)
      else $error("reset state wrong");
   chk_pc_block: assert property (o_pc_done && $past(o_pc_done) |-> !o_trig_events[10])
      else $error("pulse passed after zero");
   chk_pc_step: assert property (o_pc_armed && $past(o_pc_armed) && !$past(i_pc_write)
      && o_pc_value != $past(o_pc_value) |-> o_pc_value == $past(o_pc_value) - 20'h00001)
      else $error("count did not step by one");
   chk_pc_reload: assert property (i_pc_write && o_pc_armed && o_pc_value != 20'h00000
      && i_pc_cfg.count != 20'h00000 |=> o_pc_armed && o_pc_value == $past(i_pc_cfg.count))
      else $error("reload failed");
   chk_ic_mode: assert property (i_ic_write |=> o_ic_mode == $past(i_ic_cfg.mode))
      else $error("mode not taken");
endmodule
bind tsic_trigger_unit tsic_trigger_unit_checker chk_u (.i_clock, .i_rst_n, .i_trig_in, .i_src_write,
   .i_src_cfg, .i_pc_write, .i_pc_cfg, .i_ic_write, .i_ic_cfg, .o_trig_events, .o_trig_any, .o_src_enable,
   .o_pc_value, .o_pc_armed, .o_pc_done, .o_ic_mode);
`default_nettype wire

/* dv/tsic_encoder_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tsic_encoder_model
(
   input wire logic i_clock,
   output logic o_fine_step,
   output logic o_fine_dir_down
);
   initial
   begin
      o_fine_step = 1'b0;
      o_fine_dir_down = 1'b0;
   end
   // Steps change on the falling edge, so the unit never samples one mid-change.
   task automatic move(input int n, input logic down);
      o_fine_dir_down = down;
      repeat (n)
      begin
         o_fine_step = 1'b1;
         @(negedge i_clock);
      end
      o_fine_step = 1'b0;
   endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic i_clock;
   logic i_rst_n;
   logic [3:0] i_trig_in;
   logic [3:0] i_ref_pulse;
   logic i_track_a;
   logic i_track_b;
   logic [3:0] i_sw_trigger;
   logic i_timer_tick;
   logic [31:0] i_timer_period;
   logic i_fine_step;
   logic i_fine_dir_down;
   logic i_src_write;
   tsic_pkg::tsic_src_wr_t i_src_cfg;
   logic i_pc_write;
   tsic_pkg::tsic_pc_cfg_t i_pc_cfg;
   logic i_step_write;
   tsic_pkg::tsic_interp_t i_interp;
   tsic_pkg::tsic_edge_t i_edge;
   logic i_ic_write;
   tsic_pkg::tsic_ic_cfg_t i_ic_cfg;
   logic [11:0] o_trig_events;
   logic o_trig_any;
   logic [11:0] o_src_enable;
   logic [19:0] o_pc_value;
   logic o_pc_armed;
   logic o_pc_done;
   logic [31:0] o_aux_position;
   tsic_pkg::tsic_ic_mode_t o_ic_mode;
   int n_errors = 0;
   int checks_done = 0;
   int ev_cnt[13];
   int fac[9] = '{1, 2, 4, 5, 10, 20, 25, 50, 100};
   logic [31:0] pos;
   tsic_trigger_unit dut_u (.i_clock, .i_rst_n, .i_trig_in, .i_ref_pulse, .i_track_a, .i_track_b,
      .i_sw_trigger, .i_timer_tick, .i_timer_period, .i_fine_step, .i_fine_dir_down, .i_src_write,
      .i_src_cfg, .i_pc_write, .i_pc_cfg, .i_step_write, .i_interp, .i_edge, .i_ic_write, .i_ic_cfg,
      .o_trig_events, .o_trig_any, .o_src_enable, .o_pc_value, .o_pc_armed, .o_pc_done,
      .o_aux_position, .o_ic_mode);
   tsic_encoder_model enc_u (.i_clock, .o_fine_step(i_fine_step), .o_fine_dir_down(i_fine_dir_down));
   initial
   begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end
   always @(posedge i_clock)
   begin
      for (int i = 0; i < 12; i++)
         if (o_trig_events[i] === 1'b1) ev_cnt[i]++;
      if (o_trig_any === 1'b1) ev_cnt[12]++;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_cnt(input string nm, input int i, input int e);
      checks_done++;
      if (ev_cnt[i] != e)
      begin
         n_errors++;
         $display("[ERR] %s expected %0d seen %0d", nm, e, ev_cnt[i]);
      end
      ev_cnt[i] = 0;
   endtask
   task automatic src(input logic en, input logic all, input logic [11:0] m);
      i_src_cfg = '{en, all, m};
      i_src_write = 1'b1;
      cyc(1);
      i_src_write = 1'b0;
      cyc(1);
   endtask
   task automatic pc(input logic [3:0] s, input logic [3:0] t, input logic [19:0] c);
      i_pc_cfg = '{s, t, c};
      i_pc_write = 1'b1;
      cyc(1);
      i_pc_write = 1'b0;
      cyc(1);
   endtask
   task automatic ic(input tsic_pkg::tsic_ic_mode_t m, input tsic_pkg::tsic_ic_start_t s,
                     input logic [31:0] p, input logic [31:0] iv);
      i_ic_cfg = '{m, s, p, iv};
      i_ic_write = 1'b1;
      cyc(1);
      i_ic_write = 1'b0;
      cyc(1);
   endtask
   task automatic stp(input tsic_pkg::tsic_interp_t ip, input tsic_pkg::tsic_edge_t e, input int d);
      i_interp = ip;
      i_edge = e;
      i_step_write = 1'b1;
      cyc(1);
      i_step_write = 1'b0;
      cyc(1);
      pos = o_aux_position;
      enc_u.move(400, 1'b0);
      cyc(2);
      chk("aux_step", pos + d, o_aux_position);
   endtask
   // Pins are held two cycles so the two-flop synchroniser cannot miss them.
   task automatic pulse(input int k);
      if (k < 4) i_trig_in[k] = 1'b1;
      else i_ref_pulse[k-4] = 1'b1;
      cyc(2);
      i_trig_in = 4'h0;
      i_ref_pulse = 4'h0;
      cyc(6);
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (30000) @(negedge i_clock);
      n_errors++;
      conclude();
   end
   initial
   begin
      {i_trig_in, i_ref_pulse, i_sw_trigger} = 12'h000;
      {i_track_a, i_track_b, i_timer_tick, i_src_write, i_pc_write, i_step_write, i_ic_write} = 7'h00;
      i_timer_period = 32'h00000000;
      i_src_cfg = '0;
      i_pc_cfg = '0;
      i_ic_cfg = '0;
      i_interp = tsic_pkg::interp_1x;
      i_edge = tsic_pkg::quadruple_edge_evaluation;
      i_rst_n = 1'b0;
      cyc(16);
      i_rst_n = 1'b1;
      cyc(1);
      chk("enable", 12'h000, o_src_enable);
      chk("mode", tsic_pkg::interval_mode_off, o_ic_mode);
      chk("armed", 1'b0, o_pc_armed);
      src(1'b1, 1'b0, 12'h005);
      chk("enable", 12'h005, o_src_enable);
      src(1'b1, 1'b0, 12'h300);
      chk("enable", 12'h305, o_src_enable);
      src(1'b0, 1'b0, 12'h001);
      chk("enable", 12'h304, o_src_enable);
      src(1'b1, 1'b1, 12'h000);
      chk("enable", 12'hfff, o_src_enable);
      for (int k = 0; k < 8; k++)
      begin
         pulse(k);
         chk_cnt("pin_event", k, 1);
      end
      src(1'b0, 1'b0, 12'h001);
      pulse(0);
      chk_cnt("masked_pin", 0, 0);
      {i_track_a, i_track_b} = 2'h3;
      pulse(4);
      chk_cnt("gated_ref", 8, 1);
      i_track_b = 1'b0;
      pulse(4);
      chk_cnt("gated_ref", 8, 0);
      pc(4'h8, 4'h1, 20'h00003);
      pulse(1);
      chk_cnt("pc_idle", 10, 0);
      i_sw_trigger[0] = 1'b1;
      cyc(1);
      i_sw_trigger[0] = 1'b0;
      cyc(3);
      chk("armed", 1'b1, o_pc_armed);
      for (int i = 0; i < 4; i++)
      begin
         pulse(1);
         chk_cnt("pc_event", 10, (i < 3) ? 1 : 0);
         chk("pc_value", (i < 3) ? 2 - i : 0, o_pc_value);
      end
      chk("done", 1'b1, o_pc_done);
      pc(4'h8, 4'h1, 20'h00005);
      i_sw_trigger[0] = 1'b1;
      cyc(1);
      i_sw_trigger[0] = 1'b0;
      cyc(3);
      pulse(1);
      pc(4'h8, 4'h1, 20'hfffff);
      chk("pc_reload", 20'hfffff, o_pc_value);
      // The timer now feeds the pulse counter, whose own source stays masked below.
      pc(4'h8, 4'ha, 20'h00002);
      i_timer_period = 32'h00000003;
      src(1'b0, 1'b1, 12'h000);
      chk("enable", 12'h000, o_src_enable);
      src(1'b1, 1'b0, 12'h800);
      ev_cnt[12] = 0;
      repeat (9)
      begin
         i_timer_tick = 1'b1;
         cyc(1);
         i_timer_tick = 1'b0;
         cyc(1);
      end
      cyc(4);
      chk_cnt("timer", 11, 3);
      chk_cnt("trig_any", 12, 3);
      chk("pc_timer", 1'b1, o_pc_done);
      src(1'b1, 1'b1, 12'h000);
      for (int i = 0; i < 9; i++)
         stp(tsic_pkg::tsic_interp_t'(i), tsic_pkg::quadruple_edge_evaluation, fac[i] * 4);
      stp(tsic_pkg::interp_25x, tsic_pkg::single_edge_evaluation, 25);
      stp(tsic_pkg::interp_5x, tsic_pkg::double_edge_evaluation, 10);
      stp(tsic_pkg::interp_100x, tsic_pkg::quadruple_edge_evaluation, 400);
      ev_cnt[9] = 0;
      ic(tsic_pkg::interval_mode_off, tsic_pkg::start_at_programmed_position, 0, 0);
      ic(tsic_pkg::interval_mode_one_shot, tsic_pkg::start_at_programmed_position, o_aux_position + 10, 0);
      enc_u.move(20, 1'b0);
      cyc(4);
      chk_cnt("one_shot", 9, 1);
      ic(tsic_pkg::interval_mode_off, tsic_pkg::start_at_programmed_position, 0, 0);
      ic(tsic_pkg::interval_mode_repeat, tsic_pkg::start_at_present_position, 0, 5);
      enc_u.move(20, 1'b0);
      cyc(4);
      chk_cnt("repeat", 9, 5);
      ic(tsic_pkg::interval_mode_off, tsic_pkg::start_at_programmed_position, 0, 0);
      pos = o_aux_position;
      enc_u.move(10, 1'b1);
      cyc(4);
      chk_cnt("ic_off", 9, 0);
      chk("aux_down", pos - 10, o_aux_position);
      conclude();
   end
endmodule
`default_nettype wire
